//--- hw/dhmc_ctrl.sv
// Deep halt mode controller: entry, release, warm-up and base timer idle.
`timescale 1ns/1ps
module dhmc_ctrl
#(
    parameter int unsigned LF_TICK_CLKS = dhmc_pkg::LF_TICK_CLKS
)
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        scr1_wr_en,
    input  wire logic [7:0]  scr1_wr_data,
    input  wire logic [1:0]  current_mode,
    input  wire logic [15:0] instr_pc,
    input  wire logic [7:0]  warmup_count_value,
    input  wire logic        halt_release_pin,
    input  wire logic        key_on_wakeup,
    input  wire logic        voltage_detect_wake,
    input  wire logic        reset_pin_n,
    input  wire logic        power_on_reset,
    input  wire logic        voltage_detect_reset,
    input  wire logic        base_timer_idle_req,
    input  wire logic [1:0]  base_timer_clock_select,
    output logic [7:0]       system_control_one,
    output logic [1:0]       run_mode,
    output logic             hf_osc_enable,
    output logic             lf_osc_enable,
    output logic             core_run_enable,
    output logic             port_output_hold,
    output logic             divider_clear,
    output logic [15:0]      resume_pc,
    output logic             irq_latch_window,
    output logic             warmup_on_low_clock,
    output logic             port1_bit1,
    output logic             external_irq_five
);

    // ============================================================
    // State record.
    typedef struct packed
    {
        dhmc_pkg::dhmc_state_t state;
        logic [7:0]            scr1;
        logic [1:0]            mode;
        logic [1:0]            entry_mode;
        logic [15:0]           pc;
        logic                  pin_s1;
        logic                  pin_s2;
        logic                  pin_d;
        logic                  kwu_s1;
        logic                  kwu_s2;
        logic                  vdw_s1;
        logic                  vdw_s2;
        logic                  rp_s1;
        logic                  rp_s2;
        logic                  por_s1;
        logic                  por_s2;
        logic                  vdr_s1;
        logic                  vdr_s2;
        logic [7:0]            guard;
        logic [10:0]           presc;
        logic [15:0]           div;
        logic [18:0]           lfc;
        logic                  hf_tick;
        logic                  lf_tick;
        logic                  tap_d;
        logic                  wu_start;
        logic                  wu_low;
        logic                  hf_en;
        logic                  lf_en;
        logic                  core_en;
        logic                  hold;
        logic                  div_clr;
        logic                  irqwin;
    } dhmc_ctrl_t;

    localparam logic [7:0]  MC_CNT  = 8'(dhmc_pkg::MC_CLKS);
    localparam logic [10:0] HF_LAST = 11'(dhmc_pkg::HF_TICK_CLKS - 1);
    localparam logic [18:0] LF_LAST = 19'(LF_TICK_CLKS - 1);

    dhmc_ctrl_t r_ff;
    dhmc_ctrl_t nxt_r;
    logic       wu_done;

    // ============================================================
    // Helpers.

    // Oscillators that restart for a given mode: {high, low}.
    function automatic logic [1:0] osc_for_mode(input logic [1:0] m);
        case (m)
            dhmc_pkg::MODE_SINGLE_CLOCK_RUN_MODE: osc_for_mode = 2'b10;
            dhmc_pkg::MODE_SLOW1:   osc_for_mode = 2'b01;
            default:                osc_for_mode = 2'b11;
        endcase
    endfunction

    // True when the system clock comes from the low-frequency source.
    function automatic logic mode_is_low(input logic [1:0] m);
        mode_is_low = (m == dhmc_pkg::MODE_SLOW1) ||
                      (m == dhmc_pkg::MODE_SLOW2);
    endfunction

    function automatic logic tbt_tap(input logic [15:0] d,
                                     input logic [1:0]  sel);
        case (sel)
            2'b00:   tbt_tap = d[dhmc_pkg::TBT_TAP0];
            2'b01:   tbt_tap = d[dhmc_pkg::TBT_TAP1];
            2'b10:   tbt_tap = d[dhmc_pkg::TBT_TAP2];
            default: tbt_tap = d[dhmc_pkg::TBT_TAP3];
        endcase
    endfunction

    // ============================================================
    // Next state.
    always_comb
    begin
        logic       rst_src;
        logic       release_mode_select;
        logic       pin_rise;
        logic       wake;
        logic       tap;
        logic [1:0] osc;
        rst_src  = 1'b0;
        release_mode_select     = 1'b0;
        pin_rise = 1'b0;
        wake     = 1'b0;
        tap      = 1'b0;
        osc      = 2'b00;

        nxt_r = r_ff;
        nxt_r.div_clr  = 1'b0;
        nxt_r.wu_start = 1'b0;
        nxt_r.hf_tick  = 1'b0;
        nxt_r.lf_tick  = 1'b0;

        // Every asynchronous source is caught twice before use.
        // The sampling clock keeps running while the oscillators
        // of the core are off, so no release is missed.
        nxt_r.pin_s1 = halt_release_pin;
        nxt_r.pin_s2 = r_ff.pin_s1;
        nxt_r.pin_d  = r_ff.pin_s2;
        nxt_r.kwu_s1 = key_on_wakeup;
        nxt_r.kwu_s2 = r_ff.kwu_s1;
        nxt_r.vdw_s1 = voltage_detect_wake;
        nxt_r.vdw_s2 = r_ff.vdw_s1;
        nxt_r.rp_s1  = reset_pin_n;
        nxt_r.rp_s2  = r_ff.rp_s1;
        nxt_r.por_s1 = power_on_reset;
        nxt_r.por_s2 = r_ff.por_s1;
        nxt_r.vdr_s1 = voltage_detect_reset;
        nxt_r.vdr_s2 = r_ff.vdr_s1;

        rst_src  = !r_ff.rp_s2 || r_ff.por_s2 || r_ff.vdr_s2;
        release_mode_select     = r_ff.scr1[dhmc_pkg::SCR1_RELEASE_MODE_SELECT_BIT];
        pin_rise = r_ff.pin_s2 && !r_ff.pin_d;
        tap      = tbt_tap(r_ff.div, base_timer_clock_select);
        nxt_r.tap_d = tap;

        // Level release looks at the pin high, edge release at a rise
        // outside the first machine cycle after entry.
        if (release_mode_select)
        begin
            wake = r_ff.pin_s2;
        end
        else
        begin
            wake = pin_rise && (r_ff.guard == 8'h00);
        end
        wake = wake || r_ff.kwu_s2 ||
               (r_ff.vdw_s2 && (r_ff.guard == 8'h00));

        // Timebase runs whenever an oscillator does.
        if (r_ff.state != dhmc_pkg::ST_HALT)
        begin
            if (r_ff.presc == HF_LAST)
            begin
                nxt_r.presc   = '0;
                nxt_r.hf_tick = 1'b1;
                nxt_r.div     = r_ff.div + 16'h0001;
            end
            else
            begin
                nxt_r.presc = r_ff.presc + 11'h001;
            end
            if (r_ff.lfc == LF_LAST)
            begin
                nxt_r.lfc     = '0;
                nxt_r.lf_tick = 1'b1;
            end
            else
            begin
                nxt_r.lfc = r_ff.lfc + 19'h0_0001;
            end
        end

        case (r_ff.state)
            dhmc_pkg::ST_RUN:
            begin
                nxt_r.core_en = 1'b1;
                if (scr1_wr_en)
                begin
                    nxt_r.scr1 = scr1_wr_data;
                    if (scr1_wr_data[dhmc_pkg::SCR1_STOP_BIT])
                    begin
                        if (scr1_wr_data[dhmc_pkg::SCR1_RELEASE_MODE_SELECT_BIT] &&
                            r_ff.pin_s2)
                        begin
                            // Entry refused, core keeps running.
                            nxt_r.scr1[dhmc_pkg::SCR1_STOP_BIT] = 1'b0;
                        end
                        else
                        begin
                            nxt_r.state      = dhmc_pkg::ST_HALT;
                            nxt_r.entry_mode = current_mode;
                            nxt_r.pc         = instr_pc + 16'h0002;
                            nxt_r.hf_en      = 1'b0;
                            nxt_r.lf_en      = 1'b0;
                            nxt_r.core_en    = 1'b0;
                            nxt_r.hold       =
                                scr1_wr_data[dhmc_pkg::SCR1_PORT_OUTPUT_HOLD_ENABLE_BIT];
                            nxt_r.div_clr    = 1'b1;
                            nxt_r.presc      = '0;
                            nxt_r.div        = '0;
                            nxt_r.lfc        = '0;
                            nxt_r.guard      = MC_CNT;
                            nxt_r.irqwin     = 1'b1;
                            nxt_r.wu_low     = mode_is_low(current_mode);
                        end
                    end
                end
                else if (base_timer_idle_req)
                begin
                    nxt_r.state   = dhmc_pkg::ST_IDLE;
                    nxt_r.core_en = 1'b0;
                end
            end

            dhmc_pkg::ST_IDLE:
            begin
                // Only the base timer tap is watched here.
                if (r_ff.tap_d && !tap)
                begin
                    nxt_r.state   = dhmc_pkg::ST_RUN;
                    nxt_r.core_en = 1'b1;
                end
            end

            dhmc_pkg::ST_HALT:
            begin
                if (r_ff.guard != 8'h00)
                begin
                    nxt_r.guard = r_ff.guard - 8'h01;
                end
                if (wake)
                begin
                    osc            = osc_for_mode(r_ff.entry_mode);
                    nxt_r.state    = dhmc_pkg::ST_WARM;
                    nxt_r.hf_en    = osc[1];
                    nxt_r.lf_en    = osc[0];
                    nxt_r.wu_start = 1'b1;
                end
            end

            dhmc_pkg::ST_WARM:
            begin
                // The pin is no longer looked at, so a low level now
                // cannot send the core back to sleep.
                if (wu_done)
                begin
                    nxt_r.state   = dhmc_pkg::ST_RUN;
                    nxt_r.core_en = 1'b1;
                    nxt_r.mode    = r_ff.entry_mode;
                    nxt_r.scr1[dhmc_pkg::SCR1_STOP_BIT] = 1'b0;
                    nxt_r.hold    = 1'b0;
                    nxt_r.irqwin  = 1'b0;
                    nxt_r.div_clr = 1'b1;
                    nxt_r.presc   = '0;
                    nxt_r.div     = '0;
                end
            end

            dhmc_pkg::ST_RESET:
            begin
                nxt_r.scr1    = dhmc_pkg::SCR1_RESET;
                nxt_r.hold    = 1'b0;
                nxt_r.irqwin  = 1'b0;
                nxt_r.core_en = 1'b0;
                if (!rst_src)
                begin
                    // Reset release always warms up towards single clock.
                    nxt_r.state      = dhmc_pkg::ST_WARM;
                    nxt_r.entry_mode = dhmc_pkg::MODE_SINGLE_CLOCK_RUN_MODE;
                    nxt_r.wu_low     = 1'b0;
                    nxt_r.hf_en      = 1'b1;
                    nxt_r.lf_en      = 1'b0;
                    nxt_r.wu_start   = 1'b1;
                end
            end

            default:
            begin
                nxt_r.state = dhmc_pkg::ST_RUN;
            end
        endcase

        // Any reset source overrides every state, deep halt included.
        if (rst_src)
        begin
            nxt_r.state    = dhmc_pkg::ST_RESET;
            nxt_r.core_en  = 1'b0;
            nxt_r.hf_en    = 1'b1;
            nxt_r.lf_en    = 1'b0;
            nxt_r.hold     = 1'b0;
            nxt_r.irqwin   = 1'b0;
            nxt_r.wu_start = 1'b0;
            nxt_r.mode     = dhmc_pkg::MODE_SINGLE_CLOCK_RUN_MODE;
        end
    end

    // ============================================================
    // Registers.
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_ff         <= '0;
            r_ff.state   <= dhmc_pkg::ST_RUN;
            r_ff.scr1    <= dhmc_pkg::SCR1_RESET;
            r_ff.mode    <= dhmc_pkg::MODE_SINGLE_CLOCK_RUN_MODE;
            r_ff.rp_s1   <= 1'b1;
            r_ff.rp_s2   <= 1'b1;
            r_ff.hf_en   <= 1'b1;
            r_ff.core_en <= 1'b1;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    // ============================================================
    // Warm-up counter on the source that ran the system at entry.
    dhmc_warmup u_warmup
    (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .start       (r_ff.wu_start),
        .count_value (warmup_count_value),
        .tick        (r_ff.wu_low ? r_ff.lf_tick : r_ff.hf_tick),
        .done        (wu_done)
    );

    // ============================================================
    // Outputs.
    assign system_control_one  = r_ff.scr1;
    assign run_mode            = r_ff.mode;
    assign hf_osc_enable       = r_ff.hf_en;
    assign lf_osc_enable       = r_ff.lf_en;
    assign core_run_enable     = r_ff.core_en;
    assign port_output_hold    = r_ff.hold;
    assign divider_clear       = r_ff.div_clr;
    assign resume_pc           = r_ff.pc;
    assign irq_latch_window    = r_ff.irqwin;
    assign warmup_on_low_clock = r_ff.wu_low;
    // The same synchronised pin serves the port and the interrupt.
    assign port1_bit1          = r_ff.pin_s2;
    assign external_irq_five   = r_ff.pin_s2;

endmodule

//--- hw/dhmc_pkg.sv
// Constants and types shared by the deep halt mode controller.
// ============================================================
// How it works
// - Writing one to the entry bit of system control one enters deep halt.
// - Deep halt stops both oscillators and every internal operation.
// - Memory, CPU registers and status word keep their values while halted.
// - Port output latches follow the output hold enable bit during halt.
// - Entering deep halt clears the prescaler and divider to zero.
// - The held program counter points two addresses past the entry instruction.
// - Deep halt entry is bit 7 of system control one.
// - Reset pin, power-on and voltage detector resets also end deep halt.
// - After a reset, run the warm-up count, then single clock run mode.
// - Release pin, key-on wakeup and voltage detector wake deep halt.
// - Release mode select picks level or edge release for the pin.
// - Release mode select one: a high pin level ends deep halt.
// - Release mode select sits at bit 6 of system control one.
// - In level mode an entry request with the pin high is ignored.
// - Warm-up counts on the oscillator that drove the system at entry.
// - Interrupt latches may be set from entry until warm-up ends.
// - The release pin doubles as port1_bit1 and external_irq_five.
// - Base timer idle ends on the falling edge of the selected tap.
// - Release mode select zero: a rising pin edge ends deep halt.
// - A rising edge within one machine cycle after entry is ignored.
// - The pin falling during warm-up does not restart deep halt.
// - A wake release resumes the mode active before deep halt.
package dhmc_pkg;

    // ============================================================
    // System control one layout.
    localparam int unsigned SCR1_STOP_BIT   = 7;
    localparam int unsigned SCR1_RELEASE_MODE_SELECT_BIT   = 6;
    localparam int unsigned SCR1_PORT_OUTPUT_HOLD_ENABLE_BIT  = 4;
    localparam logic [7:0]  SCR1_RESET      = 8'h00;

    // ============================================================
    // Timing, 200 MHz system clock.
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned MACHINE_CYC_NS  = 125;
    localparam int unsigned MC_CLKS         =
        (MACHINE_CYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Warm-up unit on the high-frequency source, in ns.
    localparam int unsigned HF_UNIT_NS      = 8000;
    localparam int unsigned HF_TICK_CLKS    = HF_UNIT_NS / CLK_PERIOD_NS;
    // Warm-up unit on the low-frequency source, in ns.
    localparam int unsigned LF_UNIT_NS      = 1953000;
    localparam int unsigned LF_TICK_CLKS    = LF_UNIT_NS / CLK_PERIOD_NS;

    // Base timer taps on the divider, one per clock select code.
    localparam int unsigned TBT_TAP0        = 10;
    localparam int unsigned TBT_TAP1        = 12;
    localparam int unsigned TBT_TAP2        = 14;
    localparam int unsigned TBT_TAP3        = 15;

    // ============================================================
    // Run modes reported by the clock controller.
    typedef enum logic [1:0]
    {
        MODE_SINGLE_CLOCK_RUN_MODE = 2'b00,
        MODE_NORMAL2 = 2'b01,
        MODE_SLOW1   = 2'b10,
        MODE_SLOW2   = 2'b11
    } dhmc_mode_t;

    typedef enum logic [2:0]
    {
        ST_RUN   = 3'b000,
        ST_HALT  = 3'b001,
        ST_WARM  = 3'b010,
        ST_RESET = 3'b011,
        ST_IDLE  = 3'b100
    } dhmc_state_t;

endpackage

//--- hw/dhmc_warmup.sv
// Warm-up down counter paced by an external tick enable.
`timescale 1ns/1ps
module dhmc_warmup
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       start,
    input  wire logic [7:0] count_value,
    input  wire logic       tick,
    output logic            done
);

    // ============================================================
    // State.
    typedef struct packed
    {
        logic       busy;
        logic [7:0] cnt;
        logic       done;
    } dhmc_wu_t;

    dhmc_wu_t r_ff;
    dhmc_wu_t nxt_r;

    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        if (start)
        begin
            nxt_r.busy = 1'b1;
            nxt_r.cnt  = count_value;
        end
        else if (r_ff.busy && tick)
        begin
            // A count of zero still waits one full tick.
            if (r_ff.cnt == 8'h00)
            begin
                nxt_r.busy = 1'b0;
                nxt_r.done = 1'b1;
            end
            else
            begin
                nxt_r.cnt = r_ff.cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_ff <= '0;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign done = r_ff.done;

endmodule

//--- test/dhmc_ctrl_tb_top.sv
// Self-checking bench for the deep halt mode controller.
`timescale 1ns/1ps
module dhmc_ctrl_tb_top;
    logic        clock = '0;
    logic        sys_rst = '1;
    logic        scr1_wr_en = '0;
    logic [7:0]  scr1_wr_data = '0;
    logic [1:0]  current_mode = '0;
    logic [15:0] instr_pc = '0;
    logic [7:0]  warmup_count_value = '0;
    logic        want_pin = '0;
    logic        want_key = '0;
    logic [3:0]  lag = '0;
    logic        voltage_detect_wake = '0;
    logic        reset_pin_n = '1;
    logic        power_on_reset = '0;
    logic        voltage_detect_reset = '0;
    logic        base_timer_idle_req = '0;
    logic [1:0]  base_timer_clock_select = '0;
    logic        halt_release_pin, key_on_wakeup, divider_clear;
    logic        hf_osc_enable, lf_osc_enable, core_run_enable;
    logic        port_output_hold, irq_latch_window, warmup_on_low_clock;
    logic        port1_bit1, external_irq_five;
    logic [7:0]  system_control_one;
    logic [1:0]  run_mode;
    logic [15:0] resume_pc, pcv;
    logic [21:0] notes[$];
    logic [21:0] nt;
    logic [1:0]  cur_run = '0;
    int          n_fail = 0;
    int          checked = 0;
    int          m, s;

    // A short low-clock tick keeps slow-mode warm-ups brief.
    dhmc_ctrl #(.LF_TICK_CLKS(8)) dut_u (.*);
    dhmc_wake_model far_u (.*);
    initial forever #2.5 clock = ~clock;

    // ============================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] d);
        @(posedge clock);
        scr1_wr_en   <= 1'h1;
        scr1_wr_data <= d;
        instr_pc     <= pcv;
        @(posedge clock);
        scr1_wr_en <= 1'h0;
        @(negedge clock);
    endtask

    task automatic entry(input logic [7:0] d, input logic rel, glitch);
        pcv = 16'($urandom);
        notes.push_back({1'h1, 3'h0, cur_run, pcv + 16'h0002});
        wr(d);
        if (rel)
            notes.push_back({1'h1, 1'h1, current_mode != 2'h2,
                current_mode != 2'h0, current_mode, pcv + 16'h0002});
        if (glitch)
        begin
            want_pin <= 1'h1;
            repeat (3) @(posedge clock);
            want_pin <= 1'h0;
        end
        repeat (40) @(negedge clock);
        check(core_run_enable, 1'h0);
        check(port_output_hold, d[4]);
        check(irq_latch_window, 1'h1);
    endtask

    task automatic wait_run;
        int i;
        for (i = 0; i < 9000 && core_run_enable !== 1'h1; i++)
            @(negedge clock);
        if (i == 9000)
        begin
            n_fail++;
            end_of_test();
        end
    endtask

    // ============================================================
    // Result watcher
    // Each divider clear pulse marks a finished entry or release.
    always @(negedge clock)
        if (divider_clear === 1'h1)
        begin
            nt = notes.size() ? notes.pop_front() : 22'h0;
            check({core_run_enable, hf_osc_enable, lf_osc_enable, run_mode,
                nt[21] ? resume_pc : nt[15:0]}, nt[20:0]);
        end

    // ============================================================
    // Main sequence
    initial
    begin
        void'($urandom(64));
        repeat (6) @(posedge clock);
        sys_rst <= 1'h0;
        @(negedge clock);
        check({system_control_one, hf_osc_enable, core_run_enable},
            {8'h00, 2'h3});
        for (m = 0; m < 4; m++)
        begin
            current_mode       <= 2'(m);
            warmup_count_value <= 8'($urandom_range(1, 0));
            lag                <= 4'($urandom_range(2, 0));
            entry({3'h4, 1'($urandom), 4'h0}, 1'h1, m[0]);
            if (m == 3)
                voltage_detect_wake <= 1'h1;
            else if (m[0])
                want_key <= 1'h1;
            else
                want_pin <= 1'h1;
            wait_run();
            want_key <= 1'h0;
            want_pin <= 1'h0;
            voltage_detect_wake <= 1'h0;
            // Let the level wake sources fall before the next entry.
            repeat (8) @(posedge clock);
            cur_run = 2'(m);
        end
        wr(8'h40);
        check(system_control_one, 8'h40);
        want_pin <= 1'h1;
        repeat (12) @(posedge clock);
        wr(8'hC0);
        check({system_control_one[7], core_run_enable}, 2'h1);
        want_pin <= 1'h0;
        repeat (12) @(posedge clock);
        check(halt_release_pin, 1'h0);
        entry(8'hD0, 1'h1, 1'h0);
        want_pin <= 1'h1;
        for (s = 0; s < 50 && hf_osc_enable !== 1'h1; s++)
            @(posedge clock);
        want_pin <= 1'h0;
        wait_run();
        cur_run = current_mode;
        for (s = 0; s < 3; s++)
        begin
            entry(8'h80, 1'h0, 1'h0);
            notes.push_back({1'h0, 3'h6, 2'h0, 16'h0000});
            @(posedge clock);
            reset_pin_n          <= s != 0;
            power_on_reset       <= s == 1;
            voltage_detect_reset <= s == 2;
            repeat (10) @(negedge clock);
            check({core_run_enable, hf_osc_enable}, 2'h1);
            @(posedge clock);
            reset_pin_n          <= 1'h1;
            power_on_reset       <= 1'h0;
            voltage_detect_reset <= 1'h0;
            wait_run();
            cur_run = 2'h0;
        end
        repeat (4) @(negedge clock);
        check(notes.size(), 0);
        end_of_test();
    end
endmodule

//--- test/dhmc_monitor.sv
// Port checker for the deep halt mode controller.
`timescale 1ns/1ps
module dhmc_monitor
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        scr1_wr_en,
    input wire logic [7:0]  scr1_wr_data,
    input wire logic [1:0]  current_mode,
    input wire logic [15:0] instr_pc,
    input wire logic        halt_release_pin,
    input wire logic        reset_pin_n,
    input wire logic        power_on_reset,
    input wire logic        voltage_detect_reset,
    input wire logic [7:0]  system_control_one,
    input wire logic [1:0]  run_mode,
    input wire logic        hf_osc_enable,
    input wire logic        lf_osc_enable,
    input wire logic        core_run_enable,
    input wire logic        divider_clear,
    input wire logic [15:0] resume_pc,
    input wire logic        irq_latch_window,
    input wire logic        warmup_on_low_clock,
    input wire logic        port1_bit1,
    input wire logic        external_irq_five
);
    // ============================================================
    // Helper logic
    // Edge mode entries only, so the pin level never blurs go.
    logic       go;
    logic [1:0] mode_ff;
    assign go = scr1_wr_en && scr1_wr_data[7] && !scr1_wr_data[6]
        && core_run_enable;
    always_ff @(posedge clock or posedge sys_rst)
        if (sys_rst)
            mode_ff <= 2'h0;
        else if (scr1_wr_en && scr1_wr_data[7] && core_run_enable)
            mode_ff <= current_mode;

    // ============================================================
    // Assertions
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    entry_stop_a:
        assert property (go |=> !core_run_enable && !hf_osc_enable
            && !lf_osc_enable) else $error("Entry left a clock running.");
    entry_div_a:
        assert property (go |=> divider_clear ##1 !divider_clear)
            else $error("No single divider clear at entry.");
    entry_pc_a:
        assert property (go |=> resume_pc == $past(instr_pc) + 16'h0002)
            else $error("Held address is wrong.");
    entry_window_a:
        assert property (go |=> irq_latch_window)
            else $error("Latch window not open at entry.");
    level_refuse_a:
        assert property (halt_release_pin[*4] ##0 (scr1_wr_en
            && scr1_wr_data[7] && scr1_wr_data[6] && core_run_enable)
            |=> core_run_enable && !system_control_one[7])
            else $error("Entry taken with release pin high.");
    mode_bit_a:
        assert property (scr1_wr_en && core_run_enable
            |=> system_control_one[6] == $past(scr1_wr_data[6]))
            else $error("Release mode bit not stored.");
    pin_share_a:
        assert property (port1_bit1 == $past(halt_release_pin, 2)
            && external_irq_five == port1_bit1)
            else $error("Shared pin copies disagree.");
    warm_osc_a:
        assert property (!core_run_enable && irq_latch_window
            && (hf_osc_enable || lf_osc_enable)
            |-> hf_osc_enable == (mode_ff != 2'h2)
            && lf_osc_enable == (mode_ff != 2'h0)
            && warmup_on_low_clock == mode_ff[1])
            else $error("Warm-up on the wrong oscillator.");
    resume_mode_a:
        assert property ($rose(core_run_enable) && $past(irq_latch_window)
            |-> run_mode == mode_ff)
            else $error("Resumed in the wrong mode.");
    reset_src_a:
        assert property ((!reset_pin_n || power_on_reset
            || voltage_detect_reset)[*5]
            |-> !core_run_enable && run_mode == 2'h0)
            else $error("Reset source did not stop the core.");
    cover property (go);
    cover property (halt_release_pin ##0 scr1_wr_en && scr1_wr_data[6]);
    cover property ($rose(core_run_enable));
endmodule

bind dhmc_ctrl dhmc_monitor mon_u (.*);

//--- test/dhmc_wake_model.sv
// Release pin and key-on wakeup source with a settable lag.
`timescale 1ns/1ps
module dhmc_wake_model
(
    input  wire logic       clock,
    input  wire logic       want_pin,
    input  wire logic       want_key,
    input  wire logic [3:0] lag,
    output logic            halt_release_pin,
    output logic            key_on_wakeup
);
    // ============================================================
    // Lagged outputs
    // A slow source moves only once the request held for lag cycles.
    logic [3:0] wait_ff = 4'h0;
    logic       pin_ff  = 1'h0;
    logic       key_ff  = 1'h0;
    assign halt_release_pin = pin_ff;
    assign key_on_wakeup    = key_ff;
    always @(posedge clock)
        if ({want_pin, want_key} == {pin_ff, key_ff})
            wait_ff <= 4'h0;
        else if (wait_ff >= lag)
        begin
            pin_ff  <= want_pin;
            key_ff  <= want_key;
            wait_ff <= 4'h0;
        end
        else
            wait_ff <= wait_ff + 4'h1;
endmodule
